/* File: src/csp_sync_pins.sv */
// Purpose: Load trigger, conversion sync pin and open-drain general pins
// Assumes: Converter status arrives on clk_in; pins are asynchronous
// Notes: Output enables are active low on both pad kinds
//
// Contract
// RULE_01: Trigger low copies staged codes to active
// RULE_02: Outputs follow active codes, not staged ones
// RULE_03: Trigger ignored in closed-loop mode
// RULE_04: Sync pin high-Z until enable bit set
// RULE_05: Default function: 20 us low pulse per sequence
// RULE_06: Function select bit chooses ready level
// RULE_07: Ready function drives high only in READY
// RULE_08: Four open-drain general pins, pull low or release
// RULE_09: Outputs 1-2 and 3-4 share range and clamp
// RULE_10: Trigger is level-sensitive, repeats every cycle
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module csp_sync_pins #(
  parameter int PULSE_CYC = csp_pkg::CSP_PULSE_CYC
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire csp_pkg::csp_apb_req_type apb_req_in,
  output csp_pkg::csp_apb_rsp_type apb_rsp_out,
  input wire logic load_trigger_n_in,
  input wire logic seq_done_in,
  input wire logic adc_ready_in,
  output logic sync_pin_o_out,
  output logic sync_pin_oe_n_out,
  input wire logic [3:0] general_io_in,
  output csp_pkg::csp_gpio_drv_type general_io_out,
  output logic [csp_pkg::CSP_CODE_W*4-1:0] bipolar_code_out,
  output logic [1:0] range_pair12_out,
  output logic [1:0] clamp_pair12_out,
  output logic [1:0] range_pair34_out,
  output logic [1:0] clamp_pair34_out,
  output logic irq_out
);
  import csp_pkg::*;

  if (PULSE_CYC < 1 || PULSE_CYC > 65535) begin : g_bad_pulse
    $error("PULSE_CYC out of range");
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [CSP_CODE_W-1:0] staged_r [4];
  logic [CSP_CODE_W-1:0] active_r [4];
  logic closed_loop_r;
  logic sync_pin_enable_r;
  logic sync_pin_function_select_r;
  logic [3:0] gpio_drive_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_mask_r;
  logic [7:0] range_r;
  logic trig_s1_r, trig_s2_r;
  logic [3:0] gpio_s1_r, gpio_s2_r, gpio_prev_r;
  logic [15:0] pulse_cnt_r;
  logic sync_o_r;
  logic [31:0] rdata_r;

  logic wr_acc, rd_acc, load_now;
  logic [2:0] irq_set;
  // Read data is captured in the setup cycle so pready can stay high
  assign wr_acc = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite;
  assign rd_acc = apb_req_in.psel && !apb_req_in.pwrite && !apb_req_in.penable;
  assign load_now = !trig_s2_r && !closed_loop_r; // [RULE_03] [RULE_10]

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Only the second stage is read; the first may still be metastable
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      trig_s1_r <= 1'b1;
      trig_s2_r <= 1'b1;
      gpio_s1_r <= CSP_GPIO_RST;
      gpio_s2_r <= CSP_GPIO_RST;
      gpio_prev_r <= CSP_GPIO_RST;
    end else begin
      trig_s1_r <= load_trigger_n_in;
      trig_s2_r <= trig_s1_r;
      gpio_s1_r <= general_io_in; // [RULE_08]
      gpio_s2_r <= gpio_s1_r;
      gpio_prev_r <= gpio_s2_r;
    end
  end

  // ----------------------------------------
  // Staged and active codes
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < 4; i++) begin
        staged_r[i] <= '0;
        active_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wr_acc && hit(apb_req_in.paddr, CSP_OFF_DATA0 + 8'(i * 4))) begin
          staged_r[i] <= apb_req_in.pwdata[CSP_CODE_W-1:0];
        end
        // Copy every cycle the trigger stays low, picking up fresh writes
        if (load_now) begin
          active_r[i] <= staged_r[i]; // [RULE_01] [RULE_10]
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      bipolar_code_out[i*CSP_CODE_W +: CSP_CODE_W] = active_r[i]; // [RULE_02]
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      closed_loop_r <= 1'b0;
      sync_pin_enable_r <= 1'b0;
      sync_pin_function_select_r <= 1'b0;
      gpio_drive_r <= CSP_GPIO_RST;
      irq_mask_r <= '0;
      range_r <= '0;
    end else if (wr_acc) begin
      if (hit(apb_req_in.paddr, CSP_OFF_MODE)) begin
        closed_loop_r <= apb_req_in.pwdata[CSP_MODE_CLOSED_BIT];
      end
      if (hit(apb_req_in.paddr, CSP_OFF_SYNC_CFG)) begin
        sync_pin_enable_r <= apb_req_in.pwdata[CSP_SYNC_EN_BIT]; // [RULE_04]
        sync_pin_function_select_r <= apb_req_in.pwdata[CSP_SYNC_SEL_BIT]; // [RULE_06]
      end
      if (hit(apb_req_in.paddr, CSP_OFF_GPIO_OUT)) begin
        gpio_drive_r <= apb_req_in.pwdata[3:0];
      end
      if (hit(apb_req_in.paddr, CSP_OFF_IRQ_MASK)) begin
        irq_mask_r <= apb_req_in.pwdata[2:0];
      end
      if (hit(apb_req_in.paddr, CSP_OFF_RANGE)) begin
        range_r <= apb_req_in.pwdata[7:0];
      end
    end
  end

  // One setting per output pair, never per output
  assign range_pair12_out = range_r[1:0]; // [RULE_09]
  assign clamp_pair12_out = range_r[3:2]; // [RULE_09]
  assign range_pair34_out = range_r[5:4]; // [RULE_09]
  assign clamp_pair34_out = range_r[7:6]; // [RULE_09]

  // ----------------------------------------
  // General pins: drive low or release
  // ----------------------------------------
  assign general_io_out.o = 4'h0; // [RULE_08]
  assign general_io_out.oe_n = gpio_drive_r; // [RULE_08]

  // ----------------------------------------
  // Sync pin
  // ----------------------------------------
  // A repeated done reloads the counter, so the pulse stretches
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pulse_cnt_r <= '0;
    end else if (seq_done_in) begin
      pulse_cnt_r <= 16'(PULSE_CYC); // [RULE_05]
    end else if (pulse_cnt_r != 16'h0000) begin
      pulse_cnt_r <= pulse_cnt_r - 16'h0001;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync_o_r <= 1'b1;
    end else if (sync_pin_function_select_r) begin
      sync_o_r <= adc_ready_in; // [RULE_07]
    end else begin
      sync_o_r <= !(seq_done_in || pulse_cnt_r > 16'h0001); // [RULE_05]
    end
  end

  // The level keeps tracking while disabled; only the driver is off
  assign sync_pin_o_out = sync_o_r;
  assign sync_pin_oe_n_out = !sync_pin_enable_r; // [RULE_04]

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  assign irq_set[CSP_IRQ_DONE_BIT] = seq_done_in;
  assign irq_set[CSP_IRQ_LOAD_BIT] = load_now;
  assign irq_set[CSP_IRQ_GPIO_BIT] = |(gpio_s2_r ^ gpio_prev_r);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_stat_r <= '0;
    end else begin
      // Set beats a simultaneous write-one clear
      if (wr_acc && hit(apb_req_in.paddr, CSP_OFF_IRQ_STAT)) begin
        irq_stat_r <= (irq_stat_r & ~apb_req_in.pwdata[2:0]) | irq_set;
      end else begin
        irq_stat_r <= irq_stat_r | irq_set;
      end
    end
  end

  assign irq_out = |(irq_stat_r & irq_mask_r);

  // ----------------------------------------
  // APB read path
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_r <= '0;
    end else if (rd_acc) begin
      rdata_r <= '0;
      for (int i = 0; i < 4; i++) begin
        if (hit(apb_req_in.paddr, CSP_OFF_DATA0 + 8'(i * 4))) begin
          rdata_r <= 32'(staged_r[i]);
        end
        if (hit(apb_req_in.paddr, CSP_OFF_ACTIVE0 + 8'(i * 4))) begin
          rdata_r <= 32'(active_r[i]);
        end
      end
      if (hit(apb_req_in.paddr, CSP_OFF_MODE)) rdata_r <= 32'(closed_loop_r);
      if (hit(apb_req_in.paddr, CSP_OFF_SYNC_CFG)) begin
        rdata_r <= 32'({sync_pin_function_select_r, sync_pin_enable_r});
      end
      if (hit(apb_req_in.paddr, CSP_OFF_GPIO_OUT)) rdata_r <= 32'(gpio_drive_r);
      if (hit(apb_req_in.paddr, CSP_OFF_GPIO_IN)) rdata_r <= 32'(gpio_s2_r);
      if (hit(apb_req_in.paddr, CSP_OFF_IRQ_STAT)) rdata_r <= 32'(irq_stat_r);
      if (hit(apb_req_in.paddr, CSP_OFF_IRQ_MASK)) rdata_r <= 32'(irq_mask_r);
      if (hit(apb_req_in.paddr, CSP_OFF_RANGE)) rdata_r <= 32'(range_r);
    end
  end

  assign apb_rsp_out.prdata = rdata_r;
  assign apb_rsp_out.pready = 1'b1;
  assign apb_rsp_out.pslverr = 1'b0;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_trig_low;
    !trig_s2_r && !closed_loop_r;
  endsequence

  a_load_copies: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_01]
    s_trig_low |=> active_r[0] == $past(staged_r[0]))
    else $error("active code not loaded");
  a_no_load_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_02]
    trig_s2_r |=> $stable(bipolar_code_out))
    else $error("outputs changed without load");
  a_closed_ignore: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_03]
    closed_loop_r |=> $stable(bipolar_code_out))
    else $error("trigger honoured in closed loop");
  a_sync_hiz: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_04]
    !sync_pin_enable_r |-> sync_pin_oe_n_out)
    else $error("sync pin driven while disabled");
  a_pulse_start: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_05]
    seq_done_in && !sync_pin_function_select_r ##1 !sync_pin_function_select_r
      |-> !sync_o_r)
    else $error("done pulse missing");
  a_ready_level: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_07]
    sync_pin_function_select_r ##1 sync_pin_function_select_r
      |-> sync_o_r == $past(adc_ready_in))
    else $error("ready level wrong");
  a_gpio_od: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_08]
    general_io_out.o == 4'h0)
    else $error("general pin driven high");
  a_level_repeat: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_10]
    s_trig_low ##1 s_trig_low |=> active_r[1] == $past(staged_r[1]))
    else $error("level load not repeated");

  sequence s_pulse_idle;
    !sync_pin_function_select_r && !seq_done_in && pulse_cnt_r <= 16'h0001;
  endsequence
  sequence s_pulse_busy;
    !sync_pin_function_select_r && pulse_cnt_r > 16'h0001;
  endsequence

  // Pulse function stays high when idle and low while counting
  a_pulse_idle: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_05]
    s_pulse_idle |=> sync_o_r)
    else $error("done pin not idle high");
  a_pulse_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_05]
    s_pulse_busy |=> !sync_o_r)
    else $error("done pulse cut short");
  a_sel_switch: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_06]
    $rose(sync_pin_function_select_r) |=> sync_o_r == $past(adc_ready_in))
    else $error("function select ignored");
  a_load_flag: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE_01]
    s_trig_low |=> irq_stat_r[CSP_IRQ_LOAD_BIT])
    else $error("load flag not set");
  a_done_set_wins: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    seq_done_in |=> irq_stat_r[CSP_IRQ_DONE_BIT])
    else $error("done flag lost");
endmodule // csp_sync_pins

/* File: src/csp_pkg.sv */
// Purpose: Shared constants and types for the converter sync pin block
// Assumes: 250 MHz core clock, APB register access with 32-bit data
// Notes: Offsets are byte addresses of aligned 32-bit words
package csp_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] CSP_OFF_DATA0 = 8'h00;
  localparam logic [7:0] CSP_OFF_DATA1 = 8'h04;
  localparam logic [7:0] CSP_OFF_DATA2 = 8'h08;
  localparam logic [7:0] CSP_OFF_DATA3 = 8'h0c;
  localparam logic [7:0] CSP_OFF_MODE = 8'h10;
  // Word index of the sync configuration; its byte address is four times it
  localparam logic [7:0] CSP_IDX_SYNC_CFG = 8'h11;
  localparam logic [7:0] CSP_OFF_SYNC_CFG = CSP_IDX_SYNC_CFG << 2;
  localparam logic [7:0] CSP_OFF_GPIO_OUT = 8'h48;
  localparam logic [7:0] CSP_OFF_GPIO_IN = 8'h4c;
  localparam logic [7:0] CSP_OFF_IRQ_STAT = 8'h50;
  localparam logic [7:0] CSP_OFF_IRQ_MASK = 8'h54;
  localparam logic [7:0] CSP_OFF_ACTIVE0 = 8'h60;
  localparam logic [7:0] CSP_OFF_RANGE = 8'h70;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int CSP_SYNC_EN_BIT = 0;
  localparam int CSP_SYNC_SEL_BIT = 1;
  localparam int CSP_MODE_CLOSED_BIT = 0;
  localparam int CSP_IRQ_DONE_BIT = 0;
  localparam int CSP_IRQ_LOAD_BIT = 1;
  localparam int CSP_IRQ_GPIO_BIT = 2;
  localparam logic [3:0] CSP_GPIO_RST = 4'hf;
  localparam int CSP_CODE_W = 12;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CSP_CLK_MHZ = 250;
  localparam int CSP_PULSE_US = 20;
  localparam int CSP_PULSE_CYC = CSP_PULSE_US * CSP_CLK_MHZ;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } csp_apb_req_type;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } csp_apb_rsp_type;
  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oe_n;
  } csp_gpio_drv_type;
endpackage

/* File: sim/csp_host_model.sv */
// Purpose: Board-side model of the sync pin and the four open-drain general pins
// Assumes: Pull-ups on the general pins; none on the sync pin
// Notes: A released sync pin shows the inverse so a stale level never passes
`timescale 1ns/1ps
module csp_host_model (
  input wire logic clk_in,
  input wire logic sync_o_in,
  input wire logic sync_oe_n_in,
  input wire logic [3:0] gpio_oe_n_in,
  input wire logic [3:0] pull_low_in,
  output logic sync_line_out,
  output logic [3:0] gpio_line_out
);
  assign sync_line_out = sync_oe_n_in ? ~sync_o_in : sync_o_in;
  // Pull-up holds the line high unless either side pulls low
  assign gpio_line_out = gpio_oe_n_in & ~pull_low_in;
endmodule // csp_host_model

/* File: sim/tb_top.sv */
// Purpose: Self-checking bench for the sync pin block
// Assumes: Short sync pulse parameter of 8 cycles
// Notes: Integer model of staged and active codes
`timescale 1ns/1ps
module tb_top;
  import csp_pkg::*;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  csp_apb_req_type req = '0;
  csp_apb_rsp_type rsp;
  logic trig_n = 1'b1, done = 1'b0, rdy = 1'b0, so, soe_n, sline, prv, irq;
  logic [3:0] pull = 4'h0, gline;
  csp_gpio_drv_type gdrv;
  logic [47:0] codes;
  logic [1:0] r12, c12, r34, c34;
  logic [31:0] rd, n;
  integer seed = 32'h3d0f6c5b, fail_count = 0, check_count = 0, k, i;
  int stg[4], act[4];
  always #2 clk_in = ~clk_in;
  csp_sync_pins #(.PULSE_CYC(8)) u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .apb_req_in(req), .apb_rsp_out(rsp), .load_trigger_n_in(trig_n), .seq_done_in(done),
    .adc_ready_in(rdy), .sync_pin_o_out(so), .sync_pin_oe_n_out(soe_n),
    .general_io_in(gline), .general_io_out(gdrv), .bipolar_code_out(codes),
    .range_pair12_out(r12), .clamp_pair12_out(c12), .range_pair34_out(r34),
    .clamp_pair34_out(c34), .irq_out(irq));
  csp_host_model u_host (.clk_in(clk_in), .sync_o_in(so), .sync_oe_n_in(soe_n),
    .gpio_oe_n_in(gdrv.oe_n), .pull_low_in(pull), .sync_line_out(sline),
    .gpio_line_out(gline));
  task conclude;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(string nm, logic [63:0] seen, logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(bit w, logic [7:0] a, logic [31:0] d);
    @(posedge clk_in);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge clk_in);
    req.penable <= 1'b1;
    do @(posedge clk_in); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  function logic [47:0] mcodes();
    logic [47:0] v;
    for (int j = 0; j < 4; j++) v[12*j +: 12] = act[j][11:0];
    return v;
  endfunction
  initial begin
    #20000;
    fail_count++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    #1 chk("sync_oe_n", soe_n, 1);
    chk("gpio_oe_n", gdrv.oe_n, 4'hf);
    for (i = 0; i < 4; i++) begin
      act[i] = 0;
      stg[i] = $random(seed) & 32'hfff;
      apb(1, CSP_OFF_DATA0 + 8'(4 * i), stg[i]);
    end
    #1 chk("codes", codes, mcodes());
    apb(1, CSP_OFF_MODE, 1);
    trig_n <= 1'b0;
    repeat (6) @(posedge clk_in);
    #1 chk("codes", codes, mcodes());
    apb(1, CSP_OFF_MODE, 0);
    repeat (4) @(posedge clk_in);
    act = stg;
    #1 chk("codes", codes, mcodes());
    stg[0] = $random(seed) & 32'hfff;
    apb(1, CSP_OFF_DATA0, stg[0]);
    repeat (3) @(posedge clk_in);
    act[0] = stg[0];
    #1 chk("codes", codes, mcodes());
    @(posedge clk_in);
    trig_n <= 1'b1;
    repeat (4) @(posedge clk_in);
    apb(1, CSP_OFF_DATA1, 32'h0000_0abc);
    stg[1] = 32'h0000_0abc;
    apb(1, CSP_OFF_ACTIVE0 + 8'h04, 32'h0000_0123);
    apb(0, CSP_OFF_ACTIVE0 + 8'h04, 0);
    chk("active1", rd, act[1]);
    apb(0, CSP_OFF_DATA1, 0);
    chk("staged1", rd, stg[1]);
    #1 chk("codes", codes, mcodes());
    apb(0, 8'h3c, 0);
    chk("unmapped", rd, 0);
    n = $random(seed);
    apb(1, CSP_OFF_RANGE, n & 32'hff);
    #1 chk("range", {c34, r34, c12, r12}, n[7:0]);
    apb(1, CSP_OFF_SYNC_CFG, 1);
    #1 chk("sync_oe_n", soe_n, 0);
    @(posedge clk_in) done <= 1'b1;
    @(posedge clk_in) done <= 1'b0;
    #1 chk("sync_line", sline, 0);
    k = 0;
    while (so === 1'b0 && k < 50) begin
      @(posedge clk_in);
      #1 k++;
    end
    chk("pulse_len", k, 8);
    apb(1, CSP_OFF_SYNC_CFG, 3);
    for (i = 0; i < 12; i++) begin
      @(posedge clk_in);
      prv = rdy;
      rdy <= $random(seed);
      #1 chk("ready_lvl", sline, prv);
    end
    n = $random(seed);
    apb(1, CSP_OFF_GPIO_OUT, n & 32'hf);
    pull <= n[7:4];
    #1 chk("gpio_oe_n", gdrv.oe_n, n[3:0]);
    repeat (4) @(posedge clk_in);
    apb(0, CSP_OFF_GPIO_IN, 0);
    chk("gpio_in", rd & 32'hf, n[3:0] & ~n[7:4]);
    apb(0, CSP_OFF_IRQ_STAT, 0);
    chk("stat_all", rd[2:0], {(n[3:0] & ~n[7:4]) != 4'hf, 2'b11});
    apb(1, CSP_OFF_IRQ_MASK, 0);
    apb(1, CSP_OFF_IRQ_STAT, 7);
    @(posedge clk_in) done <= 1'b1;
    @(posedge clk_in) done <= 1'b0;
    apb(0, CSP_OFF_IRQ_STAT, 0);
    chk("stat_done", rd[2:0], 3'b001);
    chk("irq_masked", irq, 0);
    apb(1, CSP_OFF_IRQ_MASK, 1);
    #1 chk("irq_on", irq, 1);
    apb(1, CSP_OFF_IRQ_STAT, 1);
    #1 chk("irq_off", irq, 0);
    conclude();
  end
endmodule // tb_top
